// ---- mmf_pkg.sv ----
package mmf_pkg;
  // Register byte offsets
  localparam logic [7:0] MMF_OFF_FLAGS = 8'h00;
  localparam logic [7:0] MMF_OFF_ADDR = 8'h04;
  localparam logic [7:0] MMF_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] MMF_OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] MMF_OFF_SP = 8'h10;
  localparam logic [7:0] MMF_OFF_PC = 8'h14;
  // Flag bit positions
  localparam int MMF_BIT_FETCH = 0;
  localparam int MMF_BIT_DATA = 1;
  localparam int MMF_BIT_UNSTK = 3;
  localparam int MMF_BIT_STK = 4;
  localparam int MMF_BIT_AVALID = 7;
  // Implemented flag mask, reserved bits 6:5 and 2 read zero
  localparam logic [7:0] MMF_IMPL_MASK = 8'h9b;
  localparam logic [7:0] MMF_FLAGS_RST = 8'h00;
  localparam logic [31:0] MMF_WORD_RST = 32'h0000_0000;
  // Bytes in one stacked context frame
  localparam logic [31:0] MMF_FRAME_BYTES = 32'h0000_0020;
  // AXI responses
  localparam logic [1:0] MMF_RESP_OKAY = 2'h0;
  localparam logic [1:0] MMF_RESP_SLVERR = 2'h2;
  // Kind of core event
  typedef enum logic [2:0] {
    MMF_EV_NONE, MMF_EV_STACK, MMF_EV_UNSTACK, MMF_EV_DATA, MMF_EV_FETCH
  } mmf_event_e;
endpackage

// ---- mmf_fault_decode.sv ----
// Classifies one core fault report into flag set pulses
module mmf_fault_decode
  import mmf_pkg::*;
(
  // Core report
  input wire logic valid_i,
  input wire mmf_event_e kind_i,
  input wire logic mpu_violation_i,
  input wire logic execute_never_i,
  // Decoded
  output logic [7:0] set_o,
  output logic capture_o
);
  // One flag per event kind; fetch into never-exec region faults even with no MPU
  always_comb begin
    set_o = MMF_FLAGS_RST;
    capture_o = 1'b0;
    if (valid_i) begin
      case (kind_i)
        MMF_EV_STACK: set_o[MMF_BIT_STK] = mpu_violation_i;
        MMF_EV_UNSTACK: set_o[MMF_BIT_UNSTK] = mpu_violation_i;
        MMF_EV_DATA: begin
          set_o[MMF_BIT_DATA] = mpu_violation_i;
          capture_o = mpu_violation_i;
        end
        MMF_EV_FETCH: set_o[MMF_BIT_FETCH] = mpu_violation_i | execute_never_i;
        default: set_o = MMF_FLAGS_RST;
      endcase
    end
  end
endmodule

// ---- mmf_top.sv ----
module mmf_top
  import mmf_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Core fault report, single cycle pulse
  input wire logic FAULT_VALID_I,
  input wire mmf_event_e FAULT_KIND_I,
  input wire logic MPU_VIOLATION_I,
  input wire logic EXECUTE_NEVER_I,
  input wire logic [31:0] FAULT_ADDR_I,
  input wire logic [31:0] FAULT_PC_I,
  input wire logic [31:0] SP_I,
  // AXI4-Lite write
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // AXI4-Lite read
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // Core results
  output logic [31:0] SP_O,
  output logic [31:0] STACKED_PC_O,
  output logic IRQ_O
);
  typedef struct packed {
    logic [7:0] flags;
    logic [31:0] addr;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [31:0] sp;
    logic [31:0] pc;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
  } mmf_state_s;

  mmf_state_s s_q;
  mmf_state_s s_d;
  logic [7:0] set;
  logic capture;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] w1c;
  logic [7:0] rd_clear;

  // Fault classification
  mmf_fault_decode u_decode (
    .valid_i(FAULT_VALID_I),
    .kind_i(FAULT_KIND_I),
    .mpu_violation_i(MPU_VIOLATION_I),
    .execute_never_i(EXECUTE_NEVER_I),
    .set_o(set),
    .capture_o(capture)
  );

  assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign rd_fire = ARVALID_I && !s_q.rvalid;

  // Next state
  always_comb begin
    s_d = s_q;
    w1c = MMF_FLAGS_RST;
    rd_clear = MMF_FLAGS_RST;
    // Address and data accepted in either order
    if (AWVALID_I && !s_q.aw_got) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = AWADDR_I;
    end
    if (WVALID_I && !s_q.w_got) begin
      s_d.w_got = 1'b1;
      s_d.w_data = WDATA_I;
      s_d.w_strb = WSTRB_I;
    end
    // Register writes
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = MMF_RESP_OKAY;
      case (s_q.aw_addr)
        MMF_OFF_FLAGS: if (s_q.w_strb[0]) w1c = s_q.w_data[7:0] & MMF_IMPL_MASK;
        MMF_OFF_IRQ_MASK: if (s_q.w_strb[0]) s_d.irq_mask = s_q.w_data[7:0] & MMF_IMPL_MASK;
        MMF_OFF_ADDR, MMF_OFF_IRQ_STAT, MMF_OFF_SP, MMF_OFF_PC: s_d.bresp = MMF_RESP_OKAY;
        default: s_d.bresp = MMF_RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && BREADY_I) begin
      s_d.bvalid = 1'b0;
    end
    // Register reads; reading interrupt status clears it
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = MMF_RESP_OKAY;
      s_d.rdata = MMF_WORD_RST;
      case (ARADDR_I)
        MMF_OFF_FLAGS: s_d.rdata[7:0] = s_q.flags & MMF_IMPL_MASK;
        MMF_OFF_ADDR: s_d.rdata = s_q.addr;
        MMF_OFF_IRQ_STAT: begin
          s_d.rdata[7:0] = s_q.irq_stat;
          rd_clear = s_q.irq_stat;
        end
        MMF_OFF_IRQ_MASK: s_d.rdata[7:0] = s_q.irq_mask;
        MMF_OFF_SP: s_d.rdata = s_q.sp;
        MMF_OFF_PC: s_d.rdata = s_q.pc;
        default: s_d.rresp = MMF_RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && RREADY_I) begin
      s_d.rvalid = 1'b0;
    end
    // Sticky flags; a new set wins over a same-cycle clear
    s_d.flags = ((s_q.flags & ~w1c) | set) & MMF_IMPL_MASK;
    // Captured address marks valid; clearing is software's job
    if (capture) begin
      s_d.addr = FAULT_ADDR_I;
      s_d.flags[MMF_BIT_AVALID] = 1'b1;
    end
    // Stack pointer and stacked PC per fault kind
    if (set[MMF_BIT_STK]) begin
      s_d.sp = SP_I - MMF_FRAME_BYTES;
    end
    if (set[MMF_BIT_UNSTK]) begin
      s_d.sp = SP_I;
    end
    if (set[MMF_BIT_DATA] || set[MMF_BIT_FETCH]) begin
      s_d.sp = SP_I - MMF_FRAME_BYTES;
      s_d.pc = FAULT_PC_I;
    end
    // Interrupt status events
    s_d.irq_stat = ((s_q.irq_stat & ~rd_clear) | set) & MMF_IMPL_MASK;
    if (capture) begin
      s_d.irq_stat[MMF_BIT_AVALID] = 1'b1;
    end
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    // Ready outputs kept as flops of their own
    s_d.aw_rdy = !s_d.aw_got;
    s_d.w_rdy = !s_d.w_got;
    s_d.ar_rdy = !s_d.rvalid;
  end

  // State register
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      s_q <= '0;
      s_q.aw_rdy <= 1'b1;
      s_q.w_rdy <= 1'b1;
      s_q.ar_rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign AWREADY_O = s_q.aw_rdy;
  assign WREADY_O = s_q.w_rdy;
  assign BVALID_O = s_q.bvalid;
  assign BRESP_O = s_q.bresp;
  assign ARREADY_O = s_q.ar_rdy;
  assign RVALID_O = s_q.rvalid;
  assign RDATA_O = s_q.rdata;
  assign RRESP_O = s_q.rresp;
  assign SP_O = s_q.sp;
  assign STACKED_PC_O = s_q.pc;
  assign IRQ_O = s_q.irq;

  // Assertions
  sequence s_stack_ev;
    FAULT_VALID_I && FAULT_KIND_I == MMF_EV_STACK && MPU_VIOLATION_I;
  endsequence
  sequence s_fetch_ev;
    FAULT_VALID_I && FAULT_KIND_I == MMF_EV_FETCH && (MPU_VIOLATION_I || EXECUTE_NEVER_I);
  endsequence

  a_reserved_zero: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (s_q.flags & ~MMF_IMPL_MASK) == 8'h00) else $error("reserved flag bits set");
  a_stack_flag: assert property (@(posedge CLK_I) disable iff (RESET_I)
    s_stack_ev |=> s_q.flags[MMF_BIT_STK]) else $error("stacking flag not set");
  a_stack_noaddr: assert property (@(posedge CLK_I) disable iff (RESET_I)
    s_stack_ev |=> (s_q.addr == $past(s_q.addr)) && (s_q.sp == $past(SP_I) - MMF_FRAME_BYTES))
    else $error("stacking fault address or SP wrong");
  a_unstack_flag: assert property (@(posedge CLK_I) disable iff (RESET_I)
    FAULT_VALID_I && FAULT_KIND_I == MMF_EV_UNSTACK && MPU_VIOLATION_I |=> s_q.flags[MMF_BIT_UNSTK])
    else $error("unstacking flag not set");
  a_unstack_sp: assert property (@(posedge CLK_I) disable iff (RESET_I)
    FAULT_VALID_I && FAULT_KIND_I == MMF_EV_UNSTACK && MPU_VIOLATION_I
    |=> s_q.sp == $past(SP_I) && $stable(s_q.addr)) else $error("unstacking moved SP");
  a_data_capture: assert property (@(posedge CLK_I) disable iff (RESET_I)
    FAULT_VALID_I && FAULT_KIND_I == MMF_EV_DATA && MPU_VIOLATION_I
    |=> s_q.addr == $past(FAULT_ADDR_I) && s_q.flags[MMF_BIT_DATA] && s_q.flags[MMF_BIT_AVALID])
    else $error("data fault not captured");
  a_fetch_flag: assert property (@(posedge CLK_I) disable iff (RESET_I)
    s_fetch_ev |=> s_q.flags[MMF_BIT_FETCH] && s_q.pc == $past(FAULT_PC_I)) else $error("fetch fault missed");
  a_fetch_noaddr: assert property (@(posedge CLK_I) disable iff (RESET_I)
    s_fetch_ev |=> $stable(s_q.addr)) else $error("fetch fault captured address");
  a_flag_sticky: assert property (@(posedge CLK_I) disable iff (RESET_I)
    s_q.flags[MMF_BIT_DATA] && !wr_fire |=> s_q.flags[MMF_BIT_DATA]) else $error("flag dropped");
  a_irq_level: assert property (@(posedge CLK_I) disable iff (RESET_I)
    IRQ_O == |(s_q.irq_stat & s_q.irq_mask)) else $error("irq level wrong");
  a_data_pc: assert property (@(posedge CLK_I) disable iff (RESET_I)
    FAULT_VALID_I && FAULT_KIND_I == MMF_EV_DATA && MPU_VIOLATION_I
    |=> s_q.pc == $past(FAULT_PC_I)) else $error("data fault PC wrong");
  a_avalid_hold: assert property (@(posedge CLK_I) disable iff (RESET_I)
    s_q.flags[MMF_BIT_AVALID] && !wr_fire |=> s_q.flags[MMF_BIT_AVALID]) else $error("address valid dropped");
  a_ready_idle: assert property (@(posedge CLK_I) disable iff (RESET_I)
    ARREADY_O == !RVALID_O) else $error("read ready wrong");
endmodule

// ---- mmf_top_tb_top.sv ----
module mmf_top_tb_top
  import mmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, fv, mpu, exe_nv, awv, wv, bready, arv, rready;
  mmf_event_e kind;
  logic [31:0] fa, fpc, sp, wdata, rdata, sp_o, pc_o;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic aw_rdy, w_rdy, b_valid, ar_rdy, r_valid, irq;
  int err_count, comparisons;
  // Device under test
  mmf_top mmf_top_i (.CLK_I(clk), .RESET_I(rst), .FAULT_VALID_I(fv), .FAULT_KIND_I(kind),
    .MPU_VIOLATION_I(mpu), .EXECUTE_NEVER_I(exe_nv), .FAULT_ADDR_I(fa), .FAULT_PC_I(fpc), .SP_I(sp),
    .AWADDR_I(awaddr), .AWVALID_I(awv), .AWREADY_O(aw_rdy), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .WVALID_I(wv), .WREADY_O(w_rdy), .BRESP_O(bresp), .BVALID_O(b_valid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arv), .ARREADY_O(ar_rdy), .RDATA_O(rdata), .RRESP_O(rresp),
    .RVALID_O(r_valid), .RREADY_I(rready), .SP_O(sp_o), .STACKED_PC_O(pc_o), .IRQ_O(irq));
  // Clock
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // Verdict and end of run
  task conclude;
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Compare seen against expected
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bus write, both channels offered together
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    while (!got) begin
      @(posedge clk);
      awv <= awv & ~aw_rdy;
      wv <= wv & ~w_rdy;
      got = b_valid & bready;
    end
    r = bresp;
    bready <= 0;
  endtask
  // Bus read
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 0;
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    while (!got) begin
      @(posedge clk);
      arv <= arv & ~ar_rdy;
      got = r_valid & rready;
    end
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("reg", d, e);
  endtask
  // One core fault report pulse
  task flt(input mmf_event_e k, input logic m, input logic x, input logic [31:0] a, input logic [31:0] s);
    @(posedge clk);
    fv <= 1;
    kind <= k;
    mpu <= m;
    exe_nv <= x;
    fa <= a;
    fpc <= a ^ 32'h0000_0f00;
    sp <= s;
    @(posedge clk);
    fv <= 0;
    @(posedge clk);
  endtask
  task t_stack;
    logic [1:0] r;
    rc(MMF_OFF_FLAGS, 32'h0);
    flt(MMF_EV_STACK, 1, 0, 32'h0000_1234, 32'h0000_1000);
    chk("sp", sp_o, 32'h0000_0fe0);
    rc(MMF_OFF_FLAGS, 32'h0000_0010);
    rc(MMF_OFF_ADDR, 32'h0);
    wr(MMF_OFF_FLAGS, 32'h0, r);
    rc(MMF_OFF_FLAGS, 32'h0000_0010);
    wr(MMF_OFF_FLAGS, 32'h0000_00ff, r);
    rc(MMF_OFF_FLAGS, 32'h0);
    flt(MMF_EV_UNSTACK, 1, 0, 32'h0000_5678, 32'h0000_2000);
    chk("sp", sp_o, 32'h0000_2000);
    rc(MMF_OFF_FLAGS, 32'h0000_0008);
    rc(MMF_OFF_ADDR, 32'h0);
    wr(MMF_OFF_FLAGS, 32'h0000_0008, r);
  endtask
  task t_data;
    logic [1:0] r;
    flt(MMF_EV_DATA, 1, 0, 32'ha5a5_0010, 32'h0000_3000);
    chk("pc", pc_o, 32'ha5a5_0f10);
    rc(MMF_OFF_FLAGS, 32'h0000_0082);
    rc(MMF_OFF_ADDR, 32'ha5a5_0010);
    wr(MMF_OFF_FLAGS, 32'h0000_0080, r);
    rc(MMF_OFF_FLAGS, 32'h0000_0002);
    wr(MMF_OFF_FLAGS, 32'h0000_0002, r);
    flt(MMF_EV_FETCH, 0, 0, 32'h0000_0055, 32'h0000_3000);
    rc(MMF_OFF_FLAGS, 32'h0);
    flt(MMF_EV_FETCH, 0, 1, 32'h0000_0055, 32'h0000_3000);
    chk("pc", pc_o, 32'h0000_0f55);
    rc(MMF_OFF_FLAGS, 32'h0000_0001);
    rc(MMF_OFF_ADDR, 32'ha5a5_0010);
    wr(MMF_OFF_FLAGS, 32'h0000_00ff, r);
  endtask
  task t_irq;
    logic [31:0] d;
    logic [1:0] r;
    logic i0;
    rd(MMF_OFF_IRQ_STAT, d, r);
    wr(MMF_OFF_IRQ_MASK, 32'h0, r);
    flt(MMF_EV_DATA, 1, 0, 32'h0000_0040, 32'h0000_3000);
    i0 = irq;
    chk("irq", 32'(i0), 32'h0);
    wr(MMF_OFF_IRQ_MASK, 32'h0000_00ff, r);
    repeat (2) @(posedge clk);
    chk("irq", 32'(irq), 32'h1);
    rc(MMF_OFF_IRQ_STAT, 32'h0000_0082);
    rc(MMF_OFF_IRQ_STAT, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq", 32'(irq), 32'h0);
    wr(MMF_OFF_FLAGS, 32'h0000_00ff, r);
    rd(8'h40, d, r);
    chk("rresp", 32'(r), 32'(MMF_RESP_SLVERR));
    wr(8'h40, 32'h0, r);
    chk("bresp", 32'(r), 32'(MMF_RESP_SLVERR));
  endtask
  // Watchdog
  initial begin
    #(100 * 4000);
    err_count++;
    conclude();
  end
  // Main sequence
  initial begin
    {rst, fv, mpu, exe_nv, awv, wv, bready, arv, rready} = 9'h100;
    {fa, fpc, sp, wdata, awaddr, araddr} = '0;
    wstrb = 4'hf;
    kind = MMF_EV_NONE;
    repeat (3) @(posedge clk);
    rst <= 0;
    t_stack();
    t_data();
    t_irq();
    conclude();
  end
endmodule
